// ### dlm_diag.sv
// Diagnostic LEDs, status area selection and debug port command interpreter
`timescale 1ns/1ps
// Summary of operation
// - Config port LED green while its TXD or RXD line is active, else off.
// - App port LED green while its TXD or RXD line is active, else off.
// - Backplane LED off while a block is written to the backplane and none is read in the same cycle.
// - Backplane LED on while a new block is read from the backplane.
// - Port error LED lit while no communication error is present.
// - Port error LED off as soon as an error is recognized.
// - Health LED lit at power up, green while running with user config.
// - Health LED red once the program has halted; reset recovers.
// - With no receive data pending, two status areas go to the backplane.
// - Debug port stays silent until a key; M shows the main menu.
// - Question mark redisplays the command menu.
// - A enters data analyzer mode.
// - B shows block transfer statistics.
// - C shows module configuration.
// - V shows version information.
// - W warm boots the module.
// - Keys 1 and 2 show communication status of port 1 or 2; in analyzer mode they select the analyzer port.
// - Keys 6 and 7 show configuration of port 1 or 2.
// - Escape exits the program and stops all data transfer.
// - Config files move over the debug port by Ymodem.
// - Some command keys stay active though not listed on the menu.
module dlm_diag #(parameter int BIT_CYCLES_P = dlm_pkg::BIT_CYCLES) (
  input wire logic ref_clk_in,
  input wire logic reset_n_in,
  input wire logic cfg_rxd_in,
  output logic cfg_txd_out,
  input wire logic app_rxd_in,
  input wire logic app_txd_in,
  input wire logic [7:0] tx_byte_in,
  input wire logic tx_valid_in,
  output logic tx_ready_out,
  input wire logic ymodem_active_in,
  output logic [7:0] rx_byte_out,
  output logic rx_valid_out,
  input wire logic bp_read_in,
  input wire logic bp_write_in,
  input wire logic rx_data_avail_in,
  input wire logic comm_error_in,
  input wire logic config_valid_in,
  output dlm_pkg::dlm_screen_req_t screen_req_out,
  output logic analyzer_on_out,
  output logic warm_boot_out,
  output logic xfer_enable_out,
  output dlm_pkg::dlm_status_sel_t status_sel_out,
  output dlm_pkg::dlm_led_t leds_out
);
  import dlm_pkg::*;
  localparam logic [11:0] BIT_LAST_L = 12'(BIT_CYCLES_P - 1);
  localparam logic [11:0] HALF_LAST_L = 12'(BIT_CYCLES_P / 2 - 1);

  // ****************************************
  // Pin synchronisers
  // ****************************************
  logic [2:0] sync1_r;
  logic [2:0] sync2_r;
  logic cfg_rx;
  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      sync1_r <= 3'h7;
      sync2_r <= 3'h7;
    end else begin
      sync1_r <= {cfg_rxd_in, app_rxd_in, app_txd_in};
      sync2_r <= sync1_r;
    end
  end
  assign cfg_rx = sync2_r[2];

  // ****************************************
  // Debug port receiver
  // ****************************************
  logic rx_busy_r, rx_busy_nxt;
  logic [11:0] rx_cnt_r, rx_cnt_nxt;
  logic [3:0] rx_bit_r, rx_bit_nxt;
  logic [7:0] rx_sh_r, rx_sh_nxt;
  logic [7:0] rx_byte_r, rx_byte_nxt;
  logic rx_valid_r, rx_valid_nxt;
  always_comb begin
    rx_busy_nxt = rx_busy_r;
    rx_cnt_nxt = rx_cnt_r;
    rx_bit_nxt = rx_bit_r;
    rx_sh_nxt = rx_sh_r;
    rx_byte_nxt = rx_byte_r;
    rx_valid_nxt = 1'b0;
    if (!rx_busy_r) begin
      if (!cfg_rx) begin
        rx_busy_nxt = 1'b1;
        rx_cnt_nxt = HALF_LAST_L;
        rx_bit_nxt = 4'h0;
      end
    end else if (rx_cnt_r != 12'h0) begin
      rx_cnt_nxt = rx_cnt_r - 12'h1;
    end else begin
      rx_cnt_nxt = BIT_LAST_L;
      rx_bit_nxt = rx_bit_r + 4'h1;
      if (rx_bit_r == 4'h0) begin
        rx_busy_nxt = !cfg_rx;
      end else if (rx_bit_r <= LAST_DATA_IDX) begin
        rx_sh_nxt = {cfg_rx, rx_sh_r[7:1]};
      end else begin
        rx_busy_nxt = 1'b0;
        rx_valid_nxt = cfg_rx;
        rx_byte_nxt = cfg_rx ? rx_sh_r : rx_byte_r;
      end
    end
  end
  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      rx_busy_r <= 1'b0;
      rx_cnt_r <= 12'h0;
      rx_bit_r <= 4'h0;
      rx_sh_r <= 8'h0;
      rx_byte_r <= 8'h0;
      rx_valid_r <= 1'b0;
    end else begin
      rx_busy_r <= rx_busy_nxt;
      rx_cnt_r <= rx_cnt_nxt;
      rx_bit_r <= rx_bit_nxt;
      rx_sh_r <= rx_sh_nxt;
      rx_byte_r <= rx_byte_nxt;
      rx_valid_r <= rx_valid_nxt;
    end
  end
  // Raw bytes go out for the file transfer engine
  assign rx_byte_out = rx_byte_r;
  assign rx_valid_out = rx_valid_r;

  // ****************************************
  // Command interpreter
  // ****************************************
  dlm_mode_t mode_r, mode_nxt;
  logic heard_key_r, heard_key_nxt;
  logic warm_r, warm_nxt;
  dlm_screen_req_t req_r, req_nxt;
  logic [7:0] key;
  logic key_hit;
  always_comb begin
    key = rx_byte_r;
    if (rx_byte_r >= LC_FIRST && rx_byte_r <= LC_LAST) begin
      key = rx_byte_r & LC_MASK;
    end
  end
  assign key_hit = rx_valid_r && !ymodem_active_in && (mode_r != ST_HALTED);
  always_comb begin
    mode_nxt = mode_r;
    heard_key_nxt = heard_key_r;
    warm_nxt = 1'b0;
    req_nxt = REQ_NONE;
    if (key_hit) begin
      heard_key_nxt = 1'b1;
      if (mode_r == ST_ANALYZER && (key == KEY_STAT_P1 || key == KEY_STAT_P2)) begin
        req_nxt = '{1'b1, SCR_ANALYZER, key[1]};
      end else begin
        unique case (key)
          KEY_MENU: begin
            mode_nxt = ST_MENU;
            req_nxt = '{1'b1, SCR_MENU, 1'b0};
          end
          KEY_HELP: begin
            if (mode_r == ST_BLANK) begin
              mode_nxt = ST_MENU;
            end
            req_nxt = '{1'b1, SCR_MENU, 1'b0};
          end
          KEY_ANALYZER: begin
            mode_nxt = ST_ANALYZER;
            req_nxt = '{1'b1, SCR_ANALYZER, 1'b0};
          end
          KEY_BT_STATS: req_nxt = '{1'b1, SCR_BT_STATS, 1'b0};
          KEY_MOD_CFG: req_nxt = '{1'b1, SCR_MOD_CFG, 1'b0};
          KEY_VERSION: req_nxt = '{1'b1, SCR_VERSION, 1'b0};
          KEY_WARM: begin
            warm_nxt = 1'b1;
            mode_nxt = ST_BLANK;
            heard_key_nxt = 1'b0;
          end
          KEY_STAT_P1: req_nxt = '{1'b1, SCR_PORT_STAT, 1'b0};
          KEY_STAT_P2: req_nxt = '{1'b1, SCR_PORT_STAT, 1'b1};
          KEY_CFG_P1: req_nxt = '{1'b1, SCR_PORT_CFG, 1'b0};
          KEY_CFG_P2: req_nxt = '{1'b1, SCR_PORT_CFG, 1'b1};
          KEY_ESC: mode_nxt = ST_HALTED;
          default: req_nxt = REQ_NONE;
        endcase
      end
    end
  end
  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      mode_r <= ST_BLANK;
      heard_key_r <= 1'b0;
      warm_r <= 1'b0;
      req_r <= REQ_NONE;
    end else begin
      mode_r <= mode_nxt;
      heard_key_r <= heard_key_nxt;
      warm_r <= warm_nxt;
      req_r <= req_nxt;
    end
  end
  assign screen_req_out = req_r;
  assign warm_boot_out = warm_r;
  assign analyzer_on_out = (mode_r == ST_ANALYZER);
  assign xfer_enable_out = (mode_r != ST_HALTED);

  // ****************************************
  // Debug port transmitter
  // ****************************************
  logic tx_busy_r, tx_busy_nxt;
  logic [11:0] tx_cnt_r, tx_cnt_nxt;
  logic [3:0] tx_bit_r, tx_bit_nxt;
  logic [8:0] tx_sh_r, tx_sh_nxt;
  logic txd_r, txd_nxt;
  assign tx_ready_out = !tx_busy_r && heard_key_r && (mode_r != ST_HALTED);
  always_comb begin
    tx_busy_nxt = tx_busy_r;
    tx_cnt_nxt = tx_cnt_r;
    tx_bit_nxt = tx_bit_r;
    tx_sh_nxt = tx_sh_r;
    txd_nxt = txd_r;
    if (!tx_busy_r) begin
      txd_nxt = 1'b1;
      if (tx_valid_in && tx_ready_out) begin
        tx_busy_nxt = 1'b1;
        tx_sh_nxt = {1'b1, tx_byte_in};
        tx_cnt_nxt = BIT_LAST_L;
        tx_bit_nxt = 4'h0;
        txd_nxt = 1'b0;
      end
    end else if (tx_cnt_r != 12'h0) begin
      tx_cnt_nxt = tx_cnt_r - 12'h1;
    end else if (tx_bit_r == STOP_IDX) begin
      tx_busy_nxt = 1'b0;
    end else begin
      txd_nxt = tx_sh_r[0];
      tx_sh_nxt = {1'b1, tx_sh_r[8:1]};
      tx_bit_nxt = tx_bit_r + 4'h1;
      tx_cnt_nxt = BIT_LAST_L;
    end
  end
  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      tx_busy_r <= 1'b0;
      tx_cnt_r <= 12'h0;
      tx_bit_r <= 4'h0;
      tx_sh_r <= 9'h1FF;
      txd_r <= 1'b1;
    end else begin
      tx_busy_r <= tx_busy_nxt;
      tx_cnt_r <= tx_cnt_nxt;
      tx_bit_r <= tx_bit_nxt;
      tx_sh_r <= tx_sh_nxt;
      txd_r <= txd_nxt;
    end
  end
  assign cfg_txd_out = txd_r;

  // ****************************************
  // Indicators and status areas
  // ****************************************
  dlm_led_t leds_r, leds_nxt;
  dlm_status_sel_t sel_r, sel_nxt;
  logic running;
  assign running = (mode_r != ST_HALTED);
  always_comb begin
    leds_nxt = leds_r;
    sel_nxt = sel_r;
    leds_nxt.cfg_act = !cfg_rx || !txd_r;
    leds_nxt.app_act = !sync2_r[1] || !sync2_r[0];
    leds_nxt.port_err = !comm_error_in;
    leds_nxt.health_green = running && config_valid_in;
    leds_nxt.health_red = !(running && config_valid_in);
    if (running) begin
      if (bp_read_in) begin
        leds_nxt.bp_xfer = 1'b1;
      end else if (bp_write_in) begin
        leds_nxt.bp_xfer = 1'b0;
      end
      if (bp_write_in) begin
        sel_nxt.sending_status = !rx_data_avail_in;
        sel_nxt.area = rx_data_avail_in ? sel_r.area : !sel_r.area;
      end
    end
  end
  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      leds_r <= LED_RESET;
      sel_r <= '{1'b0, 1'b0};
    end else begin
      leds_r <= leds_nxt;
      sel_r <= sel_nxt;
    end
  end
  assign leds_out = leds_r;
  assign status_sel_out = sel_r;

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!reset_n_in);
  a_cfg_led_act: assert property (!cfg_rx |=> leds_r.cfg_act)
    else $error("config activity led not lit");
  a_app_led_idle: assert property (&sync2_r[1:0] |=> !leds_r.app_act)
    else $error("app activity led lit while idle");
  a_bp_write_off: assert property (running && bp_write_in && !bp_read_in
    |=> !leds_r.bp_xfer)
    else $error("backplane led on during write");
  a_bp_read_on: assert property (running && bp_read_in |=> leds_r.bp_xfer ##0
    $stable(sel_r.sending_status) || $past(bp_write_in))
    else $error("backplane led off during read");
  a_err_led_off: assert property (comm_error_in |=> !leds_r.port_err)
    else $error("error led lit during error");
  a_err_led_on: assert property (!comm_error_in [*2] |=> leds_r.port_err)
    else $error("error led dark without error");
  a_health_red: assert property (mode_r == ST_HALTED |=> leds_r.health_red
    && !leds_r.health_green)
    else $error("health led not red when halted");
  a_health_green: assert property (running && config_valid_in
    |=> leds_r.health_green)
    else $error("health led not green while running");
  a_status_area: assert property (running && bp_write_in && !rx_data_avail_in
    |=> sel_r.sending_status && (sel_r.area != $past(sel_r.area)))
    else $error("status area not alternated");
  a_silent_start: assert property (!heard_key_r |-> !tx_ready_out)
    else $error("debug port ready before a key");
  a_menu_key: assert property (key_hit && key == KEY_MENU |=> req_r.valid
    && req_r.screen == SCR_MENU ##1 !req_r.valid || key_hit)
    else $error("menu key gave no menu request");
  a_esc_halt: assert property (key_hit && key == KEY_ESC |=> mode_r == ST_HALTED
    && !xfer_enable_out ##1 !tx_ready_out)
    else $error("escape did not halt");
  a_warm_pulse: assert property (key_hit && key == KEY_WARM |=> warm_r
    && mode_r == ST_BLANK ##1 !warm_r)
    else $error("warm boot pulse wrong");
endmodule : dlm_diag

// ### dlm_diag_tb.sv
// Self-checking testbench of the diagnostic LED and debug menu block
`timescale 1ns/1ps
module dlm_diag_tb;
  import dlm_pkg::*;
  // Short bit time keeps the run brief
  localparam int TB_BIT = 32;
  logic ref_clk_in, reset_n_in, cfg_rxd, app_rxd_in, app_txd_in, bp_read_in, bp_write_in;
  logic rx_data_avail_in, comm_error_in, config_valid_in, cfg_txd_out, tx_ready_out;
  logic rx_valid_out, analyzer_on_out, warm_boot_out, xfer_enable_out, tx_valid_in;
  logic ymodem_active_in;
  logic [7:0] rx_byte_out, tx_byte_in;
  dlm_screen_req_t screen_req_out, req_seen;
  dlm_status_sel_t status_sel_out;
  dlm_led_t leds_out;
  int error_cnt = 0;
  int tests_run = 0;
  int req_cnt = 0;
  int cfg_cnt = 0;
  int warm_cnt = 0;
  int rxv_cnt = 0;
  // ****************************************
  // Device and far side
  // ****************************************
  dlm_diag #(.BIT_CYCLES_P(TB_BIT)) uut (
    .ref_clk_in(ref_clk_in), .reset_n_in(reset_n_in), .cfg_rxd_in(cfg_rxd),
    .cfg_txd_out(cfg_txd_out), .app_rxd_in(app_rxd_in), .app_txd_in(app_txd_in),
    .tx_byte_in(tx_byte_in), .tx_valid_in(tx_valid_in), .tx_ready_out(tx_ready_out),
    .ymodem_active_in(ymodem_active_in), .rx_byte_out(rx_byte_out),
    .rx_valid_out(rx_valid_out),
    .bp_read_in(bp_read_in), .bp_write_in(bp_write_in), .rx_data_avail_in(rx_data_avail_in),
    .comm_error_in(comm_error_in), .config_valid_in(config_valid_in),
    .screen_req_out(screen_req_out), .analyzer_on_out(analyzer_on_out),
    .warm_boot_out(warm_boot_out), .xfer_enable_out(xfer_enable_out),
    .status_sel_out(status_sel_out), .leds_out(leds_out)
  );
  dlm_term #(.BIT_CYCLES_P(TB_BIT)) term (
    .clk_in(ref_clk_in),
    .rxd_out(cfg_rxd)
  );
  // ****************************************
  // Clock and capture of pulses
  // ****************************************
  initial begin
    ref_clk_in = 1'b0;
    forever #2.5 ref_clk_in = ~ref_clk_in;
  end
  always @(posedge ref_clk_in) begin
    if (screen_req_out.valid === 1'b1) begin
      req_seen <= screen_req_out;
      req_cnt <= req_cnt + 1;
    end
    if (leds_out.cfg_act === 1'b1) cfg_cnt <= cfg_cnt + 1;
    if (warm_boot_out === 1'b1) warm_cnt <= warm_cnt + 1;
    if (rx_valid_out === 1'b1) rxv_cnt <= rxv_cnt + 1;
  end
  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  function automatic logic [7:0] req_code(input dlm_screen_t scr, input logic port);
    dlm_screen_req_t r;
    r = '{1'b1, scr, port};
    return 8'(r);
  endfunction : req_code
  task automatic key_req(input string what, input logic [7:0] key, input logic [7:0] exp);
    int n;
    n = req_cnt;
    term.send(key);
    tick(4);
    check(what, exp, 8'(req_seen));
    check({what, " count"}, 8'(n + 1), 8'(req_cnt));
  endtask : key_req
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk_in);
    #1;
  endtask : tick
  task automatic bp_op(input logic rd, input logic wr, input logic avail);
    @(posedge ref_clk_in);
    bp_read_in <= rd;
    bp_write_in <= wr;
    rx_data_avail_in <= avail;
    @(posedge ref_clk_in);
    bp_read_in <= 1'b0;
    bp_write_in <= 1'b0;
    tick(2);
  endtask : bp_op
  task automatic conclude;
    $display("Checks run %0d, mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : conclude
  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_leds;
    tick(2);
    check("port_err", 8'h01, 8'(leds_out.port_err));
    check("green", 8'h01, 8'(leds_out.health_green));
    check("red", 8'h00, 8'(leds_out.health_red));
    @(posedge ref_clk_in);
    comm_error_in <= 1'b1;
    tick(2);
    check("port_err err", 8'h00, 8'(leds_out.port_err));
    @(posedge ref_clk_in);
    comm_error_in <= 1'b0;
    tick(2);
    check("port_err back", 8'h01, 8'(leds_out.port_err));
    $display("t_leds done");
  endtask : t_leds
  task automatic t_bp;
    bp_op(1'b1, 1'b0, 1'b0);
    check("bp read", 8'h01, 8'(leds_out.bp_xfer));
    bp_op(1'b0, 1'b1, 1'b0);
    check("bp write", 8'h00, 8'(leds_out.bp_xfer));
    check("sel idle", 8'h03, 8'(status_sel_out));
    bp_op(1'b0, 1'b1, 1'b1);
    check("sel pending", 8'h01, 8'(status_sel_out));
    bp_op(1'b1, 1'b1, 1'b1);
    check("bp both", 8'h01, 8'(leds_out.bp_xfer));
    bp_op(1'b0, 1'b1, 1'b0);
    check("sel second area", 8'h02, 8'(status_sel_out));
    check("bp write again", 8'h00, 8'(leds_out.bp_xfer));
    $display("t_bp done");
  endtask : t_bp
  task automatic t_act;
    @(posedge ref_clk_in);
    app_rxd_in <= 1'b0;
    tick(4);
    check("app rx act", 8'h01, 8'(leds_out.app_act));
    @(posedge ref_clk_in);
    app_rxd_in <= 1'b1;
    app_txd_in <= 1'b0;
    tick(4);
    check("app tx act", 8'h01, 8'(leds_out.app_act));
    @(posedge ref_clk_in);
    app_txd_in <= 1'b1;
    tick(4);
    check("app idle", 8'h00, 8'(leds_out.app_act));
    check("cfg idle", 8'h00, 8'(leds_out.cfg_act));
    $display("t_act done");
  endtask : t_act
  task automatic t_keys;
    @(posedge ref_clk_in);
    tx_byte_in <= 8'h55;
    tx_valid_in <= 1'b1;
    tick(8);
    check("silent before key", 8'h00, 8'(tx_ready_out));
    check("txd before key", 8'h01, 8'(cfg_txd_out));
    @(posedge ref_clk_in);
    tx_valid_in <= 1'b0;
    key_req("help blank", KEY_HELP, req_code(SCR_MENU, 1'b0));
    key_req("menu req", KEY_MENU, req_code(SCR_MENU, 1'b0));
    check("key byte", KEY_MENU, rx_byte_out);
    check("ready after key", 8'h01, 8'(tx_ready_out));
    check("cfg act seen", 8'h01, 8'(cfg_cnt > 0));
    key_req("analyzer", KEY_ANALYZER, req_code(SCR_ANALYZER, 1'b0));
    check("analyzer on", 8'h01, 8'(analyzer_on_out));
    key_req("analyzer port 2", KEY_STAT_P2, req_code(SCR_ANALYZER, 1'b1));
    key_req("lower m", KEY_MENU | 8'h20, req_code(SCR_MENU, 1'b0));
    check("analyzer off", 8'h00, 8'(analyzer_on_out));
    key_req("stats", KEY_BT_STATS, req_code(SCR_BT_STATS, 1'b0));
    key_req("module cfg", KEY_MOD_CFG, req_code(SCR_MOD_CFG, 1'b0));
    key_req("version", KEY_VERSION, req_code(SCR_VERSION, 1'b0));
    key_req("status 1", KEY_STAT_P1, req_code(SCR_PORT_STAT, 1'b0));
    key_req("status 2", KEY_STAT_P2, req_code(SCR_PORT_STAT, 1'b1));
    key_req("port cfg 1", KEY_CFG_P1, req_code(SCR_PORT_CFG, 1'b0));
    key_req("port cfg 2", KEY_CFG_P2, req_code(SCR_PORT_CFG, 1'b1));
    $display("t_keys done");
  endtask : t_keys
  task automatic t_tx;
    logic [9:0] frame;
    frame = {1'b1, 8'hA5, 1'b0};
    @(posedge ref_clk_in);
    tx_byte_in <= 8'hA5;
    tx_valid_in <= 1'b1;
    @(posedge ref_clk_in);
    tx_valid_in <= 1'b0;
    tick(TB_BIT / 2);
    check("ready while busy", 8'h00, 8'(tx_ready_out));
    for (int i = 0; i < 10; i++) begin
      check("tx bit", 8'(frame[i]), 8'(cfg_txd_out));
      tick(TB_BIT);
    end
    check("ready after frame", 8'h01, 8'(tx_ready_out));
    $display("t_tx done");
  endtask : t_tx
  task automatic t_ymodem;
    int n;
    int v;
    n = req_cnt;
    v = rxv_cnt;
    @(posedge ref_clk_in);
    ymodem_active_in <= 1'b1;
    term.send(KEY_VERSION);
    tick(4);
    check("ymodem key ignored", 8'(n), 8'(req_cnt));
    check("ymodem byte", KEY_VERSION, rx_byte_out);
    check("ymodem valid", 8'(v + 1), 8'(rxv_cnt));
    @(posedge ref_clk_in);
    ymodem_active_in <= 1'b0;
    $display("t_ymodem done");
  endtask : t_ymodem
  task automatic t_halt;
    int n;
    n = warm_cnt;
    term.send(KEY_WARM);
    tick(4);
    check("warm pulse", 8'(n + 1), 8'(warm_cnt));
    check("locked after warm", 8'h00, 8'(tx_ready_out));
    n = req_cnt;
    term.send(KEY_ESC);
    tick(4);
    check("xfer stopped", 8'h00, 8'(xfer_enable_out));
    check("halt red", 8'h01, 8'(leds_out.health_red));
    check("halt green", 8'h00, 8'(leds_out.health_green));
    bp_op(1'b1, 1'b0, 1'b0);
    check("bp ignored", 8'h00, 8'(leds_out.bp_xfer));
    term.send(KEY_MENU);
    tick(4);
    check("keys after halt", 8'(n), 8'(req_cnt));
    $display("t_halt done");
  endtask : t_halt
  // ****************************************
  // Main sequence and watchdog
  // ****************************************
  initial begin
    reset_n_in = 1'b0;
    app_rxd_in = 1'b1;
    app_txd_in = 1'b1;
    bp_read_in = 1'b0;
    bp_write_in = 1'b0;
    rx_data_avail_in = 1'b0;
    comm_error_in = 1'b0;
    config_valid_in = 1'b1;
    tx_valid_in = 1'b0;
    tx_byte_in = 8'h00;
    ymodem_active_in = 1'b0;
    repeat (5) @(posedge ref_clk_in);
    reset_n_in <= 1'b1;
    t_leds();
    t_bp();
    t_act();
    t_keys();
    t_tx();
    t_ymodem();
    t_halt();
    conclude();
  end
  initial begin
    #400000;
    error_cnt++;
    $display("[FAIL] run time expected below limit seen over");
    conclude();
  end
endmodule : dlm_diag_tb

// ### dlm_pkg.sv
// Constants and types of the diagnostic LED and debug menu block
package dlm_pkg;
  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_HZ = 200_000_000;
  localparam int BAUD_RATE = 57600;
  localparam int BIT_CYCLES = (CLK_HZ + BAUD_RATE / 2) / BAUD_RATE;
  localparam logic [11:0] BIT_LAST = 12'(BIT_CYCLES - 1);
  localparam logic [11:0] HALF_LAST = 12'(BIT_CYCLES / 2 - 1);
  localparam logic [3:0] STOP_IDX = 4'h9;
  localparam logic [3:0] LAST_DATA_IDX = 4'h8;
  // ****************************************
  // Command keys
  // ****************************************
  localparam logic [7:0] KEY_MENU = 8'h4D;
  localparam logic [7:0] KEY_HELP = 8'h3F;
  localparam logic [7:0] KEY_ANALYZER = 8'h41;
  localparam logic [7:0] KEY_BT_STATS = 8'h42;
  localparam logic [7:0] KEY_MOD_CFG = 8'h43;
  localparam logic [7:0] KEY_VERSION = 8'h56;
  localparam logic [7:0] KEY_WARM = 8'h57;
  localparam logic [7:0] KEY_STAT_P1 = 8'h31;
  localparam logic [7:0] KEY_STAT_P2 = 8'h32;
  localparam logic [7:0] KEY_CFG_P1 = 8'h36;
  localparam logic [7:0] KEY_CFG_P2 = 8'h37;
  localparam logic [7:0] KEY_ESC = 8'h1B;
  localparam logic [7:0] LC_FIRST = 8'h61;
  localparam logic [7:0] LC_LAST = 8'h7A;
  localparam logic [7:0] LC_MASK = 8'hDF;
  // ****************************************
  // Types
  // ****************************************
  typedef enum logic [1:0] {
    ST_BLANK = 2'b00,
    ST_MENU = 2'b01,
    ST_ANALYZER = 2'b11,
    ST_HALTED = 2'b10
  } dlm_mode_t;
  typedef enum logic [2:0] {
    SCR_MENU = 3'h0,
    SCR_ANALYZER = 3'h1,
    SCR_BT_STATS = 3'h2,
    SCR_MOD_CFG = 3'h3,
    SCR_VERSION = 3'h4,
    SCR_PORT_STAT = 3'h5,
    SCR_PORT_CFG = 3'h6
  } dlm_screen_t;
  typedef struct packed {
    logic valid;
    dlm_screen_t screen;
    logic port;
  } dlm_screen_req_t;
  typedef struct packed {
    logic cfg_act;
    logic app_act;
    logic bp_xfer;
    logic port_err;
    logic health_green;
    logic health_red;
  } dlm_led_t;
  typedef struct packed {
    logic sending_status;
    logic area;
  } dlm_status_sel_t;
  localparam dlm_screen_req_t REQ_NONE = '{1'b0, SCR_MENU, 1'b0};
  localparam dlm_led_t LED_RESET = '{1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 1'b1};
endpackage : dlm_pkg

// ### dlm_term.sv
// Terminal emulator model on the debug serial link
`timescale 1ns/1ps
module dlm_term #(parameter int BIT_CYCLES_P = dlm_pkg::BIT_CYCLES) (
  input wire logic clk_in,
  output logic rxd_out
);
  import dlm_pkg::*;
  // ****************************************
  // Idle line
  // ****************************************
  initial begin
    rxd_out = 1'b1; // Idle high between frames
  end
  // ****************************************
  // One key, 8N1, LSB first
  // ****************************************
  task automatic send(input logic [7:0] key);
    logic [9:0] frame;
    frame = {1'b1, key, 1'b0}; // Start, data, one stop, no parity
    for (int i = 0; i < 10; i++) begin
      @(posedge clk_in);
      rxd_out <= frame[i];
      repeat (BIT_CYCLES_P - 1) @(posedge clk_in);
    end
    @(posedge clk_in);
  endtask : send
endmodule : dlm_term
